// ===== design/ufl_params.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the serial port queue control, interrupt identity and line format.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef UFL_PARAMS_SVH
`define UFL_PARAMS_SVH

// Register offsets
`define UFL_OFS_IDENTITY     3'h2
`define UFL_OFS_QUEUE_CTRL   3'h2
`define UFL_OFS_LINE_FORMAT  3'h3

// Queue control fields
`define UFL_QC_ENABLE        0
`define UFL_QC_RX_FLUSH      1
`define UFL_QC_TX_FLUSH      2
`define UFL_QC_MODE          3
`define UFL_QC_TRIG_LO       6

// Line format fields
`define UFL_LF_STOP          2
`define UFL_LF_PAR_EN        3
`define UFL_LF_PAR_EVEN      4
`define UFL_LF_PAR_STICK     5
`define UFL_LF_DIV_SEL       7

// Interrupt identity codes, bits 3..0
`define UFL_ID_NONE          4'h1
`define UFL_ID_LINE          4'h6
`define UFL_ID_DATA          4'h4
`define UFL_ID_TIMEOUT       4'hc
`define UFL_ID_THRE          4'h2
`define UFL_ID_MODEM         4'h0

// Reset values
`define UFL_RST_LINE_FORMAT  8'h00
`define UFL_RST_IDENTITY     8'h01

// Timeout span in character times
`define UFL_TIMEOUT_CHARS    4

`endif

// ===== design/ufl_pkg.sv
/*
 * Types for the serial port queue control, interrupt identity and
 * line format block. Assumes no other package.
 */
package ufl_pkg;

	// Line format as seen by the shifters
	typedef struct packed {
		logic [3:0] word_bits;
		logic [2:0] stop_half_bits;
		logic       parity_en;
	} ufl_format_t;

	// Whole state of the core
	typedef struct packed {
		ufl_format_t fmt;
		logic       irq_pend;
		logic       stop_chk;
		logic       fifo_en;
		logic [1:0] trig;
		logic       mode;
		logic [7:0] line_format_control;
		logic [7:0] interrupt_identity;
		logic [7:0] rdata;
		logic       rx_flush;
		logic       tx_flush;
		logic       ls_pend;
		logic       thre_pend;
		logic       ms_pend;
		logic       thr_empty_d;
		logic       to_pend;
		logic [7:0] to_cnt;
		logic       tx_par;
		logic       rx_perr;
	} ufl_state_t;

endpackage

// ===== design/ufl_core.sv
/*
 * Queue control, interrupt identity and line format of a buffered
 * serial port. Assumes the data queues, shifters, line status, modem
 * status, interrupt enable and divisor latches sit outside and report
 * their events here; strobes and events are one-cycle pulses.
 */
// Decided for this implementation: the strobed register port.
// Summary of operation
// - Queue enable one turns both queues on; zero turns off and empties them.
// - Leaving buffered mode empties both queues without a flush command.
// - Receive flush empties receive queue, keeps shifter, clears itself.
// - Transmit flush empties transmit queue, keeps shifter, clears itself.
// - Transfer signalling mode bit has no effect on operation.
// - Top two queue control bits pick trigger 1, 4, 8 or 14 bytes.
// - Priority: line status, received data or timeout, transmit empty, modem.
// - Identity is held stable during a host read of it.
// - Identity bit zero reads zero when an enabled interrupt is pending.
// - Bit three marks timeout in buffered mode; zero otherwise.
// - Identity bits four, five read zero; six, seven follow queue enable.
// - Identity codes per source; data available clears below trigger.
// - Line status interrupt set by receive errors, cleared by status read.
// - Transmit empty clears on identity read reporting it or holding write.
// - Modem status interrupt set by input changes, cleared by status read.
// - Format bits one, zero give five to eight data bits.
// - Stop field gives one, or one and a half / two stop bits.
// - Receiver checks only the first stop bit.
// - Parity enable inserts and checks parity after the last data bit.
// - Parity select zero gives odd parity, one gives even.
// - Stick parity sends and expects the inverse of the select bit.
// - Format bit seven steers offsets zero and one to divisor latches.
`timescale 1ns/1ns
`include "ufl_params.svh"

module ufl_core #(
	parameter int COUNT_W = 5
) (
	// Clock and reset
	input  wire logic               clock_in,
	input  wire logic               rst_b_in,
	// Register port
	input  wire logic [2:0]         addr_in,
	input  wire logic [7:0]         wr_data_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	output logic      [7:0]         rd_data_out,
	// Neighbour events and levels
	input  wire logic [3:0]         ier_in,
	input  wire logic [COUNT_W-1:0] rx_count_in,
	input  wire logic               rx_push_in,
	input  wire logic               rx_pop_in,
	input  wire logic               rx_ready_in,
	input  wire logic               lsr_error_in,
	input  wire logic               lsr_read_in,
	input  wire logic               msr_change_in,
	input  wire logic               msr_read_in,
	input  wire logic               thr_empty_in,
	input  wire logic               thr_write_in,
	input  wire logic               half_bit_tick_in,
	// Parity data
	input  wire logic [7:0]         tx_data_in,
	input  wire logic [7:0]         rx_data_in,
	input  wire logic               rx_parity_in,
	// Control outputs
	output logic                    fifo_enable_out,
	output logic                    rx_flush_out,
	output logic                    tx_flush_out,
	output logic                    divisor_latch_select_out,
	output ufl_pkg::ufl_format_t    format_out,
	output logic                    rx_stop_check_out,
	output logic                    tx_parity_bit_out,
	output logic                    rx_parity_error_out,
	output logic                    interrupt_pending_out
);

	ufl_pkg::ufl_state_t state_reg;
	ufl_pkg::ufl_state_t state_next;

	// Parity bit for a word under the given format
	function automatic logic parity_of(input logic [7:0] data,
	                                   input logic [7:0] line_format_control);
		logic [7:0] mask;
		logic       ones;
		mask = 8'h1f;
		unique case (line_format_control[1:0])
			2'h0: mask = 8'h1f;
			2'h1: mask = 8'h3f;
			2'h2: mask = 8'h7f;
			2'h3: mask = 8'hff;
		endcase
		ones = ^(data & mask);
		if (line_format_control[`UFL_LF_PAR_STICK])
			parity_of = ~line_format_control[`UFL_LF_PAR_EVEN];
		else if (line_format_control[`UFL_LF_PAR_EVEN])
			parity_of = ones;
		else
			parity_of = ~ones;
	endfunction

	// Trigger level in bytes
	function automatic logic [COUNT_W-1:0] trig_bytes(input logic [1:0] t);
		trig_bytes = COUNT_W'(1);
		unique case (t)
			2'h0: trig_bytes = COUNT_W'(1);
			2'h1: trig_bytes = COUNT_W'(4);
			2'h2: trig_bytes = COUNT_W'(8);
			2'h3: trig_bytes = COUNT_W'(14);
		endcase
	endfunction

	// Character shape for a line format value
	function automatic ufl_pkg::ufl_format_t fmt_of(input logic [7:0] line_format_control);
		fmt_of.word_bits = 4'(5) + {2'h0, line_format_control[1:0]};
		if (!line_format_control[`UFL_LF_STOP])
			fmt_of.stop_half_bits = 3'h2;
		else if (line_format_control[1:0] == 2'h0)
			fmt_of.stop_half_bits = 3'h3;
		else
			fmt_of.stop_half_bits = 3'h4;
		fmt_of.parity_en = line_format_control[`UFL_LF_PAR_EN];
	endfunction

	ufl_pkg::ufl_format_t fmt_now;
	logic [7:0] char_half;
	logic [7:0] to_limit;
	logic       data_avail;
	logic       ls_act;
	logic       rd_act;
	logic       to_act;
	logic       thre_act;
	logic       ms_act;
	logic [3:0] id_code;
	logic       qc_wr;
	logic       lf_wr;
	logic       id_rd;

	always_comb begin
		qc_wr = wr_in && addr_in == `UFL_OFS_QUEUE_CTRL;
		lf_wr = wr_in && addr_in == `UFL_OFS_LINE_FORMAT;
		id_rd = rd_in && addr_in == `UFL_OFS_IDENTITY;

		// Character length in half bits
		fmt_now = fmt_of(state_reg.line_format_control);
		char_half = 8'(2 * (1 + fmt_now.word_bits
			+ {3'h0, fmt_now.parity_en})) + {5'h0, fmt_now.stop_half_bits};
		to_limit = 8'(`UFL_TIMEOUT_CHARS * char_half);

		// Interrupt sources gated by enables
		if (state_reg.fifo_en)
			data_avail = rx_count_in >= trig_bytes(state_reg.trig);
		else
			data_avail = rx_ready_in;
		ls_act = ier_in[2] && state_reg.ls_pend;
		rd_act = ier_in[0] && data_avail;
		to_act = ier_in[0] && state_reg.fifo_en && state_reg.to_pend;
		thre_act = ier_in[1] && state_reg.thre_pend;
		ms_act = ier_in[3] && state_reg.ms_pend;

		if (ls_act)
			id_code = `UFL_ID_LINE;
		else if (rd_act)
			id_code = `UFL_ID_DATA;
		else if (to_act)
			id_code = `UFL_ID_TIMEOUT;
		else if (thre_act)
			id_code = `UFL_ID_THRE;
		else if (ms_act)
			id_code = `UFL_ID_MODEM;
		else
			id_code = `UFL_ID_NONE;

		state_next = state_reg;
		state_next.rx_flush = 1'b0;
		state_next.tx_flush = 1'b0;

		// Queue control write
		if (qc_wr) begin
			state_next.fifo_en = wr_data_in[`UFL_QC_ENABLE];
			if (wr_data_in[`UFL_QC_ENABLE]) begin
				state_next.trig = wr_data_in[`UFL_QC_TRIG_LO +: 2];
				state_next.mode = wr_data_in[`UFL_QC_MODE];
				state_next.rx_flush = wr_data_in[`UFL_QC_RX_FLUSH];
				state_next.tx_flush = wr_data_in[`UFL_QC_TX_FLUSH];
			end else begin
				state_next.rx_flush = 1'b1;
				state_next.tx_flush = 1'b1;
			end
		end

		// Line format write
		if (lf_wr)
			state_next.line_format_control = wr_data_in;

		// Line status pending, set wins over clear
		if (lsr_read_in)
			state_next.ls_pend = 1'b0;
		if (lsr_error_in)
			state_next.ls_pend = 1'b1;

		// Transmit empty pending on rising empty
		state_next.thr_empty_d = thr_empty_in;
		if (thr_write_in || (id_rd && id_code == `UFL_ID_THRE))
			state_next.thre_pend = 1'b0;
		if (thr_empty_in && !state_reg.thr_empty_d)
			state_next.thre_pend = 1'b1;

		// Modem status pending
		if (msr_read_in)
			state_next.ms_pend = 1'b0;
		if (msr_change_in)
			state_next.ms_pend = 1'b1;

		// Character timeout
		if (rx_push_in || rx_pop_in || rx_count_in == '0
			|| !state_reg.fifo_en) begin
			state_next.to_cnt = 8'h00;
			state_next.to_pend = 1'b0;
		end else if (half_bit_tick_in && !state_reg.to_pend) begin
			state_next.to_cnt = state_reg.to_cnt + 8'h01;
			if (state_reg.to_cnt + 8'h01 >= to_limit)
				state_next.to_pend = 1'b1;
		end

		// Identity frozen while it is read
		if (!id_rd)
			state_next.interrupt_identity = {{2{state_reg.fifo_en}}, 2'h0,
				id_code};
		state_next.irq_pend = ~state_next.interrupt_identity[0];
		state_next.fmt = fmt_of(state_next.line_format_control);
		state_next.stop_chk = 1'b1;

		// Read data, valid in the cycle after the strobe
		state_next.rdata = 8'h00;
		if (rd_in) begin
			unique case (addr_in)
				`UFL_OFS_IDENTITY: state_next.rdata = state_reg.interrupt_identity;
				`UFL_OFS_LINE_FORMAT: state_next.rdata = state_reg.line_format_control;
				default: state_next.rdata = 8'h00;
			endcase
		end

		// Parity for the shifters
		state_next.tx_par = parity_of(tx_data_in, state_reg.line_format_control);
		state_next.rx_perr = state_reg.line_format_control[`UFL_LF_PAR_EN]
			&& (rx_parity_in != parity_of(rx_data_in, state_reg.line_format_control));
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= '0;
			state_reg.line_format_control <= `UFL_RST_LINE_FORMAT;
			state_reg.interrupt_identity <= `UFL_RST_IDENTITY;
			state_reg.fmt.word_bits <= 4'h5;
			state_reg.fmt.stop_half_bits <= 3'h2;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data_out = state_reg.rdata;
	assign fifo_enable_out = state_reg.fifo_en;
	assign rx_flush_out = state_reg.rx_flush;
	assign tx_flush_out = state_reg.tx_flush;
	assign divisor_latch_select_out = state_reg.line_format_control[`UFL_LF_DIV_SEL];
	assign format_out = state_reg.fmt;
	assign rx_stop_check_out = state_reg.stop_chk;
	assign tx_parity_bit_out = state_reg.tx_par;
	assign rx_parity_error_out = state_reg.rx_perr;
	assign interrupt_pending_out = state_reg.irq_pend;

endmodule // ufl_core

// ===== test/ufl_core_assertions.sv
/* Port checker for ufl_core.
   Assumes the bind below and one clock domain. */
`timescale 1ns/1ns
module ufl_core_assertions (
	// Clock, reset, register port
	input wire logic                 clock_in,
	input wire logic                 rst_b_in,
	input wire logic [2:0]           addr_in,
	input wire logic [7:0]           wr_data_in,
	input wire logic                 wr_in,
	input wire logic                 rd_in,
	input wire logic [7:0]           rd_data_out,
	// Control outputs
	input wire logic                 fifo_enable_out,
	input wire logic                 rx_flush_out,
	input wire logic                 tx_flush_out,
	input wire logic                 divisor_latch_select_out,
	input wire ufl_pkg::ufl_format_t format_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_qc;
		wr_in && addr_in == 3'h2;
	endsequence
	sequence s_lf;
		wr_in && addr_in == 3'h3;
	endsequence
	property p_off;
		s_qc ##0 !wr_data_in[0] |=>
			rx_flush_out && tx_flush_out && !fifo_enable_out;
	endproperty
	a_off: assert property (p_off) else $error("off");
	property p_en;
		s_qc |=> fifo_enable_out == $past(wr_data_in[0]);
	endproperty
	a_en: assert property (p_en) else $error("enable");
	property p_rxf;
		s_qc ##0 wr_data_in[1:0] == 2'h3 |=> rx_flush_out;
	endproperty
	a_rxf: assert property (p_rxf) else $error("rx flush");
	property p_txf;
		s_qc ##0 wr_data_in[2:0] == 3'h5 |=> tx_flush_out;
	endproperty
	a_txf: assert property (p_txf) else $error("tx flush");
	property p_self;
		(rx_flush_out || tx_flush_out) && !wr_in |=>
			!rx_flush_out && !tx_flush_out;
	endproperty
	a_self: assert property (p_self) else $error("self clear");
	property p_fmt;
		s_lf |=> format_out.word_bits == 4'h5 + $past(wr_data_in[1:0])
			&& format_out.parity_en == $past(wr_data_in[3])
			&& divisor_latch_select_out == $past(wr_data_in[7]);
	endproperty
	a_fmt: assert property (p_fmt) else $error("format");
	property p_stop;
		s_lf |=> format_out.stop_half_bits == (!$past(wr_data_in[2]) ? 3'h2
			: $past(wr_data_in[1:0]) == 2'h0 ? 3'h3 : 3'h4);
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_id;
		rd_in && addr_in == 3'h2 |=> rd_data_out[5:4] == 2'h0 &&
			rd_data_out[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hc};
	endproperty
	a_id: assert property (p_id) else $error("identity");
endmodule // ufl_core_assertions

bind ufl_core ufl_core_assertions u_ufl_core_assertions (.clock_in,
	.rst_b_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
	.fifo_enable_out, .rx_flush_out, .tx_flush_out,
	.divisor_latch_select_out, .format_out);

// ===== test/ufl_peer_model.sv
/* Receive queue count and half-bit tick of the serial peer side.
   Assumes one clock and the core's receive flush pulse. */
`timescale 1ns/1ns
module ufl_peer_model (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_b_in,
	// Queue events
	input  wire logic       push_in,
	input  wire logic       pop_in,
	input  wire logic       flush_in,
	// Levels to the core
	output logic      [4:0] count_out,
	output logic            tick_out
);
	logic [1:0] div_reg;
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count_out <= 5'h00;
			div_reg   <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (flush_in)
				count_out <= 5'h00;
			else
				count_out <= count_out + 5'(push_in) - 5'(pop_in);
		end
	end
	assign tick_out = (div_reg == 2'h3);
endmodule // ufl_peer_model

// ===== test/ufl_core_tb.sv
/* Scenario bench for ufl_core.
   Assumes the bound checker and the peer queue model. */
`timescale 1ns/1ns
module ufl_core_tb;
	logic                 clock_in, rst_b_in, wr_in, rd_in, tick;
	logic                 thr_empty_in, rx_parity_in;
	logic [2:0]           addr_in;
	logic [7:0]           wr_data_in, rd_data_out, tx_data_in, rx_data_in;
	logic [3:0]           ier_in;
	logic [4:0]           rx_count_in;
	logic [6:0]           ev;
	logic                 fifo_enable_out, rx_flush_out, tx_flush_out;
	logic                 divisor_latch_select_out, rx_stop_check_out;
	logic                 tx_parity_bit_out, rx_parity_error_out;
	logic                 interrupt_pending_out;
	ufl_pkg::ufl_format_t format_out;
	int                   n_mismatch = 0, checked = 0, cyc = 0;

	ufl_core u_ufl_core (.clock_in, .rst_b_in, .addr_in, .wr_data_in, .wr_in,
		.rd_in, .rd_data_out, .ier_in, .rx_count_in, .rx_push_in(ev[6]),
		.rx_pop_in(ev[5]), .rx_ready_in(1'b0), .lsr_error_in(ev[4]),
		.lsr_read_in(ev[3]), .msr_change_in(ev[2]), .msr_read_in(ev[1]),
		.thr_empty_in, .thr_write_in(ev[0]), .half_bit_tick_in(tick),
		.tx_data_in, .rx_data_in, .rx_parity_in, .fifo_enable_out,
		.rx_flush_out, .tx_flush_out, .divisor_latch_select_out, .format_out,
		.rx_stop_check_out, .tx_parity_bit_out, .rx_parity_error_out,
		.interrupt_pending_out);
	ufl_peer_model u_ufl_peer_model (.clock_in, .rst_b_in, .push_in(ev[6]),
		.pop_in(ev[5]), .flush_in(rx_flush_out), .count_out(rx_count_in),
		.tick_out(tick));

	task automatic give_verdict;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		checked++;
		if (e !== g) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in    <= a;
		wr_data_in <= d;
		wr_in      <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e, string nm);
		@(posedge clock_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 chk(nm, e, rd_data_out);
	endtask
	task automatic pulse(input logic [6:0] m);
		@(posedge clock_in);
		ev <= m;
		@(posedge clock_in);
		ev <= 7'h00;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	task automatic t_format;
		for (int i = 0; i < 8; i++) begin
			wr(3'h3, 8'(i));
			#1 chk("words", 8'(5 + i % 4), 8'(format_out.word_bits));
			chk("stops", i < 4 ? 8'h02 : i == 4 ? 8'h03 : 8'h04,
				8'(format_out.stop_half_bits));
			rdc(3'h3, 8'(i), "line_format");
		end
		for (int i = 0; i < 4; i++) begin
			wr(3'h3, 8'h0b + 8'(i << 4));
			wt(3);
			chk("tx_par", 8'(i == 1 || i == 2), 8'(tx_parity_bit_out));
			for (int k = 0; k < 2; k++) begin
				rx_parity_in <= (i == 1 || i == 2) ^ k[0];
				wt(3);
				chk("rx_err", 8'(k), 8'(rx_parity_error_out));
			end
		end
		wr(3'h3, 8'h80);
		#1 chk("div_sel", 8'h01, 8'(divisor_latch_select_out));
		wr(3'h3, 8'h00);
		chk("stop_chk", 8'h01, 8'(rx_stop_check_out));
		$display("format done");
	endtask
	task automatic t_trigger;
		int lv[4] = '{1, 4, 8, 14};
		for (int t = 0; t < 4; t++) begin
			wr(3'h2, {2'(t), 2'h0, 1'(t), 3'h3});
			wt(3);
			for (int n = 1; n < lv[t]; n++) pulse(7'h40);
			rdc(3'h2, 8'hc1, "below");
			pulse(7'h40);
			rdc(3'h2, 8'hc4, "at_trig");
			pulse(7'h20);
			rdc(3'h2, 8'hc1, "popped");
		end
		wr(3'h2, 8'hc3);
		pulse(7'h40);
		wt(180);
		rdc(3'h2, 8'hc1, "early");
		wt(80);
		rdc(3'h2, 8'hcc, "timeout");
		pulse(7'h20);
		rdc(3'h2, 8'hc1, "to_clear");
		$display("trigger done");
	endtask
	task automatic t_priority;
		ier_in <= 4'hf;
		pulse(7'h14);
		thr_empty_in <= 1'b1;
		wt(3);
		chk("pending", 8'h01, 8'(interrupt_pending_out));
		rdc(3'h2, 8'hc6, "line");
		pulse(7'h08);
		rdc(3'h2, 8'hc2, "thre");
		rdc(3'h2, 8'hc0, "modem");
		pulse(7'h02);
		rdc(3'h2, 8'hc1, "none");
		thr_empty_in <= 1'b0;
		wt(2);
		thr_empty_in <= 1'b1;
		pulse(7'h01);
		rdc(3'h2, 8'hc1, "thr_wr");
		$display("priority done");
	endtask
	task automatic t_disable;
		pulse(7'h40);
		wr(3'h2, 8'hc5);
		#1 chk("tx_only", 8'h01, {6'h00, rx_flush_out, tx_flush_out});
		wt(1);
		chk("kept", 8'h01, 8'(rx_count_in));
		wr(3'h2, 8'h00);
		#1 chk("both", 8'h03, {6'h00, rx_flush_out, tx_flush_out});
		chk("enable", 8'h00, 8'(fifo_enable_out));
		wt(1);
		chk("cleared", 8'h00, {6'h00, rx_flush_out, tx_flush_out});
		rdc(3'h2, 8'h01, "plain_id");
		$display("disable done");
	endtask

	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict;
		end
	end
	initial begin
		{rst_b_in, wr_in, rd_in, thr_empty_in, rx_parity_in} = 5'h00;
		{addr_in, wr_data_in, ev} = 18'h00000;
		{tx_data_in, rx_data_in, ier_in} = 20'h07071;
		repeat (2) @(posedge clock_in);
		rst_b_in <= 1'b1;
		rdc(3'h2, 8'h01, "reset_id");
		rdc(3'h5, 8'h00, "unmapped");
		t_format;
		t_trigger;
		t_priority;
		t_disable;
		give_verdict;
	end
endmodule // ufl_core_tb
